// [rtl/tss_pkg.sv]
// Package of types and constants for the task switch sequencer
package tss_pkg;
  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    K_JUMP = 2'h0,
    K_INVOKE = 2'h1,
    K_INTR = 2'h2,
    K_INTERRUPT_RETURN = 2'h3
  } tss_kind_t;
  typedef enum logic [2:0] {
    F_NONE = 3'h0,
    F_GP = 3'h1,
    F_NP = 3'h2,
    F_TS = 3'h3,
    F_SF = 3'h4,
    F_PG = 3'h5
  } tss_fk_t;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_LINK = 7'h02,
    S_CHECK = 7'h04,
    S_SAVE = 7'h08,
    S_COMMIT = 7'h10,
    S_LOAD = 7'h20,
    S_FIN = 7'h40
  } tss_st_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    tss_kind_t kind;
    logic via_gate;
    logic [1:0] requested_privilege;
    logic [1:0] gate_dpl;
    logic [15:0] sel;
    logic present;
    logic [3:0] dtype;
    logic [1:0] descriptor_privilege;
    logic [31:0] limit;
    logic [31:0] base;
    logic [31:0] desc_addr;
    logic resident;
  } tss_req_t;
  typedef struct packed {
    logic ldt_ok;
    logic ldt_pres;
    logic cs_ok;
    logic cs_pres;
    logic [1:0] cs_dpl;
    logic ss_ok;
    logic ss_pres;
    logic [1:0] ss_dpl;
    logic [3:0] ds_ok;
    logic [3:0] ds_pres;
    logic [3:0] ds_conf;
    logic [3:0][1:0] ds_dpl;
  } tss_chk_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } tss_mem_t;
  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [31:0] data;
  } tss_load_t;
  typedef struct packed {
    logic valid;
    logic post;
    tss_fk_t kind;
    logic [15:0] sel;
  } tss_flt_t;
  typedef struct packed {
    logic [15:0] pad;
    tss_st_t st;
    logic [1:0] current_privilege;
    tss_fk_t fkind;
    logic fpost;
    logic busy;
    logic nt;
    logic ts;
  } tss_stat_t;

  // ==========================================================
  // Descriptor and segment layout
  localparam logic [31:0] MIN_LIMIT = 32'h0000_0067;
  localparam logic [3:0] TYPE_IDLE = 4'h9;
  localparam logic [3:0] TYPE_BUSY = 4'hB;
  localparam logic [31:0] TYPE_OFF = 32'h0000_0005;
  localparam logic [31:0] LINK_OFF = 32'h0000_0000;
  localparam logic [31:0] CTX_OFF = 32'h0000_0004;
  localparam int SEL_TI = 2;
  localparam int NT_BIT = 14;
  localparam logic [4:0] LDT_IDX = 5'h00;
  localparam logic [4:0] STW_IDX = 5'h02;
  localparam logic [4:0] SAVE_FIRST = 5'h02;
  localparam logic [4:0] SEG_IDX0 = 5'h0C;
  localparam logic [4:0] CS_IDX = 5'h0C;
  localparam logic [4:0] LAST_IDX = 5'h11;
  localparam int NDATA = 4;

  // ==========================================================
  // Register map
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_TR_SEL = 3'h1;
  localparam logic [2:0] REG_TR_BASE = 3'h2;
  localparam logic [2:0] REG_TR_DESC = 3'h3;
  localparam logic [2:0] REG_STAT = 3'h4;
  localparam int CTRL_NT = 0;
  localparam int CTRL_TSC = 1;
endpackage

// [rtl/tss_seq.sv]
// Task switch sequencer: checks, save, commit and load of task context
`timescale 1ns/10ps

module tss_seq (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_trig,
  input wire tss_pkg::tss_req_t i_req,
  input wire logic [31:0] i_cur_word,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire tss_pkg::tss_chk_t i_chk,
  input wire logic [2:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  output logic [31:0] o_reg_rdata,
  output tss_pkg::tss_mem_t o_mem,
  output logic [4:0] o_ctx_idx,
  output tss_pkg::tss_load_t o_load,
  output tss_pkg::tss_flt_t o_fault,
  output logic o_done,
  output logic o_busy,
  output logic [15:0] o_tr_sel,
  output logic o_nt,
  output logic o_ts,
  output logic [1:0] o_cpl
);
  // ==========================================================
  // State
  typedef struct packed {
    tss_pkg::tss_st_t st;
    tss_pkg::tss_req_t r;
    logic [4:0] ctx;
    logic [1:0] cstep;
    logic [15:0] ldt_sel;
    logic [5:0][15:0] segs;
    logic [15:0] old_sel;
    logic [31:0] old_desc;
    logic nt;
    logic ts;
    logic [1:0] current_privilege;
    logic [15:0] tr_sel;
    logic [31:0] tr_base;
    logic [31:0] tr_desc;
    tss_pkg::tss_mem_t mem;
    tss_pkg::tss_load_t ld;
    tss_pkg::tss_flt_t flt;
    logic done;
    logic busy;
    logic [31:0] rdata;
  } tss_state_t;

  tss_state_t s_q;
  tss_state_t s_d;
  tss_pkg::tss_fk_t pre_k;
  logic [15:0] pre_sel;
  tss_pkg::tss_fk_t post_k;
  logic [15:0] post_sel;
  logic [3:0] d_inv;
  logic [3:0] d_abs;
  logic [3:0] d_prv;
  logic nested;
  logic clr_old;
  logic need;
  logic [31:0] c_addr;
  logic [31:0] c_data;
  logic [31:0] ctx_off;
  tss_pkg::tss_stat_t stat;

  // First set bit, lowest index wins
  function automatic logic [1:0] first_set(input logic [3:0] v);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = tss_pkg::NDATA - 1; i >= 0; i--) begin
      if (v[i]) idx = 2'(i);
    end
    return idx;
  endfunction

  // ==========================================================
  // Per data segment checks
  for (genvar g = 0; g < tss_pkg::NDATA; g++) begin : g_data
    assign d_inv[g] = !i_chk.ds_ok[g];
    assign d_abs[g] = !i_chk.ds_pres[g];
    assign d_prv[g] = !i_chk.ds_conf[g] && (i_chk.ds_dpl[g] < s_q.current_privilege);
  end

  // Switch kind properties
  assign nested = (s_q.r.kind == tss_pkg::K_INVOKE) || (s_q.r.kind == tss_pkg::K_INTR);
  assign clr_old = (s_q.r.kind == tss_pkg::K_JUMP) || (s_q.r.kind == tss_pkg::K_INTERRUPT_RETURN);
  assign ctx_off = tss_pkg::CTX_OFF + 32'({s_q.ctx, 2'b00});

  // Checks before the commit point, fixed order
  always_comb begin
    pre_k = tss_pkg::F_NONE;
    pre_sel = s_q.r.sel;
    if (!nested && s_q.r.kind == tss_pkg::K_JUMP || s_q.r.kind == tss_pkg::K_INVOKE) begin
      if ((s_q.current_privilege > (s_q.r.via_gate ? s_q.r.gate_dpl : s_q.r.descriptor_privilege)) ||
          (s_q.r.requested_privilege > (s_q.r.via_gate ? s_q.r.gate_dpl : s_q.r.descriptor_privilege))) begin
        pre_k = tss_pkg::F_GP;
      end
    end
    if (pre_k != tss_pkg::F_NONE) begin
      pre_k = tss_pkg::F_GP;
    end else if (s_q.r.sel[tss_pkg::SEL_TI]) begin
      pre_k = tss_pkg::F_GP;
    end else if (!s_q.r.present) begin
      pre_k = tss_pkg::F_NP;
    end else if (s_q.r.kind == tss_pkg::K_INTERRUPT_RETURN && s_q.r.dtype != tss_pkg::TYPE_BUSY) begin
      pre_k = tss_pkg::F_TS;
    end else if (s_q.r.kind != tss_pkg::K_INTERRUPT_RETURN && s_q.r.dtype == tss_pkg::TYPE_BUSY) begin
      pre_k = tss_pkg::F_GP;
    end else if (s_q.r.limit < tss_pkg::MIN_LIMIT) begin
      pre_k = tss_pkg::F_TS;
    end else if (!s_q.r.resident) begin
      pre_k = tss_pkg::F_PG;
    end
  end

  // Checks on the loaded context, first failure only
  always_comb begin
    post_k = tss_pkg::F_TS;
    post_sel = s_q.segs[0];
    if (!i_chk.ldt_ok) begin
      post_sel = s_q.ldt_sel;
    end else if (i_chk.cs_dpl != s_q.segs[0][1:0]) begin
      post_sel = s_q.segs[0];
    end else if (!i_chk.ss_ok) begin
      post_sel = s_q.segs[1];
    end else if (!i_chk.ss_pres) begin
      post_k = tss_pkg::F_SF;
      post_sel = s_q.segs[1];
    end else if (i_chk.ss_dpl != s_q.current_privilege) begin
      post_sel = s_q.segs[1];
    end else if (!i_chk.ldt_pres) begin
      post_sel = s_q.ldt_sel;
    end else if (!i_chk.cs_ok) begin
      post_sel = s_q.segs[0];
    end else if (!i_chk.cs_pres) begin
      post_k = tss_pkg::F_NP;
    end else if (i_chk.ss_dpl != s_q.segs[1][1:0]) begin
      post_sel = s_q.segs[1];
    end else if (|d_inv) begin
      post_sel = s_q.segs[3'(first_set(d_inv)) + 3'h2];
    end else if (|d_abs) begin
      post_k = tss_pkg::F_NP;
      post_sel = s_q.segs[3'(first_set(d_abs)) + 3'h2];
    end else if (|d_prv) begin
      post_sel = s_q.segs[3'(first_set(d_prv)) + 3'h2];
    end else begin
      post_k = tss_pkg::F_NONE;
    end
  end

  // Descriptor and link writes of the commit phase
  always_comb begin
    need = 1'b0;
    c_addr = s_q.r.desc_addr + tss_pkg::TYPE_OFF;
    c_data = {28'h0000000, tss_pkg::TYPE_BUSY};
    if (s_q.cstep == 2'h0) begin
      need = clr_old;
      c_addr = s_q.old_desc + tss_pkg::TYPE_OFF;
      c_data = {28'h0000000, tss_pkg::TYPE_IDLE};
    end else if (s_q.cstep == 2'h1) begin
      need = s_q.r.kind != tss_pkg::K_INTERRUPT_RETURN;
    end else begin
      need = nested;
      c_addr = s_q.r.base + tss_pkg::LINK_OFF;
      c_data = {16'h0000, s_q.old_sel};
    end
  end

  // Status word seen by software
  always_comb begin
    stat = '0;
    stat.st = s_q.st;
    stat.current_privilege = s_q.current_privilege;
    stat.fkind = s_q.flt.kind;
    stat.fpost = s_q.flt.post;
    stat.busy = s_q.busy;
    stat.nt = s_q.nt;
    stat.ts = s_q.ts;
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.ld.valid = 1'b0;
    s_d.flt.valid = 1'b0;
    s_d.rdata = '0;
    // Register writes; task state only while idle
    if (i_reg_we && i_reg_addr == tss_pkg::REG_CTRL) begin
      if (i_reg_wdata[tss_pkg::CTRL_TSC]) s_d.ts = 1'b0;
      if (s_q.st == tss_pkg::S_IDLE) s_d.nt = i_reg_wdata[tss_pkg::CTRL_NT];
    end else if (i_reg_we && s_q.st == tss_pkg::S_IDLE) begin
      if (i_reg_addr == tss_pkg::REG_TR_SEL) begin
        s_d.tr_sel = i_reg_wdata[15:0];
      end else if (i_reg_addr == tss_pkg::REG_TR_BASE) begin
        s_d.tr_base = i_reg_wdata;
      end else if (i_reg_addr == tss_pkg::REG_TR_DESC) begin
        s_d.tr_desc = i_reg_wdata;
      end
    end
    // Register reads
    if (i_reg_re) begin
      if (i_reg_addr == tss_pkg::REG_CTRL) begin
        s_d.rdata = 32'({s_q.ts, s_q.nt});
      end else if (i_reg_addr == tss_pkg::REG_TR_SEL) begin
        s_d.rdata = {16'h0000, s_q.tr_sel};
      end else if (i_reg_addr == tss_pkg::REG_TR_BASE) begin
        s_d.rdata = s_q.tr_base;
      end else if (i_reg_addr == tss_pkg::REG_TR_DESC) begin
        s_d.rdata = s_q.tr_desc;
      end else if (i_reg_addr == tss_pkg::REG_STAT) begin
        s_d.rdata = stat;
      end
    end
    case (s_q.st)
      tss_pkg::S_IDLE: begin
        if (i_trig && !(i_req.kind == tss_pkg::K_INTERRUPT_RETURN && !s_q.nt)) begin
          s_d.r = i_req;
          s_d.busy = 1'b1;
          s_d.st = (i_req.kind == tss_pkg::K_INTERRUPT_RETURN) ? tss_pkg::S_LINK : tss_pkg::S_CHECK;
        end
      end
      tss_pkg::S_LINK: begin
        if (!s_q.mem.req) begin
          s_d.mem = '{1'b1, 1'b0, s_q.tr_base + tss_pkg::LINK_OFF, 32'h0000_0000};
        end else if (i_mem_ack) begin
          s_d.mem.req = 1'b0;
          s_d.r.sel = i_mem_rdata[15:0];
          s_d.st = tss_pkg::S_CHECK;
        end
      end
      tss_pkg::S_CHECK: begin
        if (pre_k != tss_pkg::F_NONE) begin
          s_d.flt = '{1'b1, 1'b0, pre_k, pre_sel};
          s_d.busy = 1'b0;
          s_d.st = tss_pkg::S_IDLE;
        end else begin
          s_d.ctx = tss_pkg::SAVE_FIRST;
          s_d.st = tss_pkg::S_SAVE;
        end
      end
      tss_pkg::S_SAVE: begin
        if (!s_q.mem.req) begin
          s_d.mem = '{1'b1, 1'b1, s_q.tr_base + ctx_off, i_cur_word};
          if (s_q.ctx == tss_pkg::STW_IDX && s_q.r.kind == tss_pkg::K_INTERRUPT_RETURN) begin
            s_d.mem.wdata[tss_pkg::NT_BIT] = 1'b0;
          end
        end else if (i_mem_ack) begin
          s_d.mem.req = 1'b0;
          s_d.ctx = s_q.ctx + 5'h01;
          if (s_q.ctx == tss_pkg::LAST_IDX) begin
            s_d.old_sel = s_q.tr_sel;
            s_d.old_desc = s_q.tr_desc;
            s_d.tr_sel = s_q.r.sel;
            s_d.tr_base = s_q.r.base;
            s_d.tr_desc = s_q.r.desc_addr;
            s_d.ts = 1'b1;
            s_d.cstep = 2'h0;
            s_d.st = tss_pkg::S_COMMIT;
          end
        end
      end
      tss_pkg::S_COMMIT: begin
        if (need && !s_q.mem.req) begin
          s_d.mem = '{1'b1, 1'b1, c_addr, c_data};
        end else if (!need || i_mem_ack) begin
          s_d.mem.req = 1'b0;
          s_d.cstep = s_q.cstep + 2'h1;
          if (s_q.cstep == 2'h2) begin
            s_d.ctx = tss_pkg::LDT_IDX;
            s_d.st = tss_pkg::S_LOAD;
          end
        end
      end
      tss_pkg::S_LOAD: begin
        if (!s_q.mem.req) begin
          s_d.mem = '{1'b1, 1'b0, s_q.r.base + ctx_off, 32'h0000_0000};
        end else if (i_mem_ack) begin
          s_d.mem.req = 1'b0;
          s_d.ld = '{1'b1, s_q.ctx, i_mem_rdata};
          s_d.ctx = s_q.ctx + 5'h01;
          if (s_q.ctx == tss_pkg::LDT_IDX) s_d.ldt_sel = i_mem_rdata[15:0];
          if (s_q.ctx == tss_pkg::STW_IDX) s_d.nt = i_mem_rdata[tss_pkg::NT_BIT];
          if (s_q.ctx >= tss_pkg::SEG_IDX0) begin
            s_d.segs[3'(s_q.ctx - tss_pkg::SEG_IDX0)] = i_mem_rdata[15:0];
          end
          if (s_q.ctx == tss_pkg::CS_IDX) s_d.current_privilege = i_mem_rdata[1:0];
          if (s_q.ctx == tss_pkg::LAST_IDX) s_d.st = tss_pkg::S_FIN;
        end
      end
      tss_pkg::S_FIN: begin
        if (nested) s_d.nt = 1'b1;
        s_d.flt = '{post_k != tss_pkg::F_NONE, 1'b1, post_k, post_sel};
        s_d.done = 1'b1;
        s_d.busy = 1'b0;
        s_d.st = tss_pkg::S_IDLE;
      end
      default: begin
        s_d.st = tss_pkg::S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
      s_q.st <= tss_pkg::S_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign o_reg_rdata = s_q.rdata;
  assign o_mem = s_q.mem;
  assign o_ctx_idx = s_q.ctx;
  assign o_load = s_q.ld;
  assign o_fault = s_q.flt;
  assign o_done = s_q.done;
  assign o_busy = s_q.busy;
  assign o_tr_sel = s_q.tr_sel;
  assign o_nt = s_q.nt;
  assign o_ts = s_q.ts;
  assign o_cpl = s_q.current_privilege;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_early_abort: assert property (
    s_q.st == tss_pkg::S_CHECK && pre_k != tss_pkg::F_NONE |=>
      o_fault.valid && !o_fault.post && $stable(o_tr_sel) && !o_busy)
    else $error("early fault did not abandon switch");
  a_commit_go: assert property (
    s_q.st == tss_pkg::S_CHECK && pre_k == tss_pkg::F_NONE |=> s_q.st == tss_pkg::S_SAVE)
    else $error("clean checks did not start save");
  a_limit_min: assert property (
    s_q.st == tss_pkg::S_CHECK && s_q.r.limit < tss_pkg::MIN_LIMIT |=> o_fault.valid)
    else $error("short limit not faulted");
  a_resident_chk: assert property (
    s_q.st == tss_pkg::S_CHECK && !s_q.r.resident |=> o_fault.valid && !o_fault.post)
    else $error("non resident structure not faulted");
  a_global_sel: assert property (
    s_q.st == tss_pkg::S_CHECK && s_q.r.sel[tss_pkg::SEL_TI] |=>
      o_fault.kind == tss_pkg::F_GP)
    else $error("local selector not faulted");
  a_commit_tr: assert property (
    s_q.st == tss_pkg::S_SAVE ##1 s_q.st == tss_pkg::S_COMMIT |->
      o_ts && o_tr_sel == s_q.r.sel)
    else $error("commit did not load task register");
  a_nest_flag: assert property (
    s_q.st == tss_pkg::S_FIN && nested |=> o_nt && o_done)
    else $error("nesting switch left flag clear");
  a_cpl_load: assert property (
    s_q.st == tss_pkg::S_LOAD && i_mem_ack && s_q.mem.req && s_q.ctx == tss_pkg::CS_IDX |=>
      o_cpl == $past(i_mem_rdata[1:0]))
    else $error("privilege not taken from code selector");
  a_interrupt_return_plain: assert property (
    s_q.st == tss_pkg::S_IDLE && i_trig && i_req.kind == tss_pkg::K_INTERRUPT_RETURN && !s_q.nt |=>
      s_q.st == tss_pkg::S_IDLE && !o_busy)
    else $error("plain return started a switch");
  a_late_report: assert property (
    s_q.st == tss_pkg::S_FIN |=> o_done && o_fault.post && !o_busy)
    else $error("late outcome not reported with completion");

  c_clean: cover property (o_done && !o_fault.valid);
  c_early: cover property (o_fault.valid && !o_fault.post);
  c_late: cover property (o_done && o_fault.valid);
endmodule

// [test/tss_mem_model.sv]
// Behavioural system memory answering the sequencer's word accesses
`timescale 1ns/10ps
module tss_mem_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire tss_pkg::tss_mem_t i_mem,
  input wire logic i_slow,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic done_q;
  int wait_cnt;
  // ==========================================================
  // Access handling
  // One ack per request, prompt or after a stall; idle data keeps toggling
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h0;
      done_q <= 1'b0;
      wait_cnt = 0;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (!i_mem.req) begin
        done_q <= 1'b0;
        wait_cnt = 0;
      end else if (!done_q && !o_ack) begin
        wait_cnt++;
        if (wait_cnt > (i_slow ? 3 : 0)) begin
          o_ack <= 1'b1;
          done_q <= 1'b1;
          if (i_mem.we) begin
            mem[i_mem.addr] = i_mem.wdata;
          end else begin
            o_rdata <= mem.exists(i_mem.addr) ? mem[i_mem.addr] : ~i_mem.addr;
          end
        end
      end
    end
  end
endmodule

// [test/tss_seq_tb_top.sv]
// Self-checking testbench of the task switch sequencer
`timescale 1ns/10ps
module tss_seq_tb_top;
  typedef struct {
    tss_pkg::tss_req_t r;
    tss_pkg::tss_fk_t f;
  } tss_row_t;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic trig = 1'b0;
  logic slow = 1'b0;
  tss_pkg::tss_req_t req = '0;
  tss_pkg::tss_chk_t chk_in = '0;
  logic [2:0] ra = 3'h0;
  logic [31:0] rwd = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] cur_word;
  logic ack;
  logic [31:0] rdata;
  logic [31:0] rrd;
  tss_pkg::tss_mem_t mem;
  logic [4:0] idx;
  tss_pkg::tss_load_t ld;
  tss_pkg::tss_flt_t flt;
  tss_pkg::tss_flt_t got;
  logic done;
  logic busy;
  logic nt;
  logic ts;
  logic got_done;
  logic [15:0] tr;
  logic [1:0] current_privilege;
  logic [31:0] lw [18];
  logic [31:0] v;
  tss_row_t rows [9];
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nload = 0;
  int lat = 0;

  // Current context word tagged with its index in bits 20:16, selector privilege bits clear
  assign cur_word = 32'hC0004000 | {11'h0, idx, 16'h0};

  tss_seq i_tss_seq (.i_clk(i_clk), .i_rstn(i_rstn), .i_trig(trig), .i_req(req),
    .i_cur_word(cur_word), .i_mem_ack(ack), .i_mem_rdata(rdata), .i_chk(chk_in),
    .i_reg_addr(ra), .i_reg_wdata(rwd), .i_reg_we(we), .i_reg_re(re), .o_reg_rdata(rrd),
    .o_mem(mem), .o_ctx_idx(idx), .o_load(ld), .o_fault(flt), .o_done(done),
    .o_busy(busy), .o_tr_sel(tr), .o_nt(nt), .o_ts(ts), .o_cpl(current_privilege));
  tss_mem_model i_tss_mem_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_mem(mem),
    .i_slow(slow), .o_ack(ack), .o_rdata(rdata));

  // ==========================================================
  // Clock, watchdog, load capture
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (ld.valid === 1'b1) begin
      nload++;
      lw[ld.idx] = ld.data;
    end
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge i_clk);
    ra <= a;
    rwd <= d;
    we <= 1'b1;
    @(posedge i_clk);
    we <= 1'b0;
  endtask
  task automatic reg_rd(input logic [2:0] a);
    @(posedge i_clk);
    ra <= a;
    re <= 1'b1;
    @(posedge i_clk);
    re <= 1'b0;
    #1 v = rrd;
  endtask
  function automatic tss_pkg::tss_req_t mk(input tss_pkg::tss_kind_t k, input logic g,
      input logic [1:0] gd, input logic [1:0] rp, input logic [15:0] s, input logic p,
      input logic [3:0] ty, input logic [1:0] dp, input logic [31:0] lim, input logic res,
      input logic [31:0] b, input logic [31:0] da);
    return '{k, g, rp, gd, s, p, ty, dp, lim, b, da, res};
  endfunction
  // Trigger one switch and wait for its end under a bound
  task automatic run_sw(input tss_pkg::tss_req_t r);
    @(posedge i_clk);
    nload = 0;
    req <= r;
    trig <= 1'b1;
    @(posedge i_clk);
    trig <= 1'b0;
    lat = 0;
    #1;
    while (flt.valid !== 1'b1 && done !== 1'b1 && lat < 2000) begin
      @(posedge i_clk);
      #1;
      lat++;
    end
    if (lat >= 2000) error_cnt++;
    got = flt;
    got_done = done;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rows[0] = '{mk(tss_pkg::K_JUMP, 1'h0, 2'h0, 2'h3, 16'h0010, 1'h1, 4'h9, 2'h0, 32'h67, 1'h1,
      32'h4000, 32'h400), tss_pkg::F_GP};
    rows[1] = '{mk(tss_pkg::K_INTR, 1'h1, 2'h0, 2'h3, 16'h0010, 1'h0, 4'h9, 2'h0, 32'h67, 1'h1,
      32'h4000, 32'h400), tss_pkg::F_NP};
    rows[2] = '{mk(tss_pkg::K_JUMP, 1'h0, 2'h0, 2'h0, 16'h0014, 1'h1, 4'h9, 2'h0, 32'h67, 1'h1,
      32'h4000, 32'h400), tss_pkg::F_GP};
    rows[3] = '{mk(tss_pkg::K_INVOKE, 1'h0, 2'h0, 2'h0, 16'h0010, 1'h0, 4'h9, 2'h0, 32'h67,
      1'h1, 32'h4000, 32'h400), tss_pkg::F_NP};
    rows[4] = '{mk(tss_pkg::K_JUMP, 1'h0, 2'h0, 2'h0, 16'h0010, 1'h1, 4'hB, 2'h0, 32'h67, 1'h1,
      32'h4000, 32'h400), tss_pkg::F_GP};
    rows[5] = '{mk(tss_pkg::K_JUMP, 1'h0, 2'h0, 2'h0, 16'h0010, 1'h1, 4'h9, 2'h0, 32'h66, 1'h1,
      32'h4000, 32'h400), tss_pkg::F_TS};
    rows[6] = '{mk(tss_pkg::K_JUMP, 1'h0, 2'h0, 2'h0, 16'h0010, 1'h1, 4'h9, 2'h0, 32'h67, 1'h0,
      32'h4000, 32'h400), tss_pkg::F_PG};
    rows[7] = '{mk(tss_pkg::K_INVOKE, 1'h1, 2'h3, 2'h3, 16'h0010, 1'h1, 4'h9, 2'h0, 32'h66,
      1'h1, 32'h4000, 32'h400), tss_pkg::F_TS};
    rows[8] = '{mk(tss_pkg::K_JUMP, 1'h0, 2'h0, 2'h0, 16'h0014, 1'h0, 4'h9, 2'h0, 32'h67, 1'h1,
      32'h4000, 32'h400), tss_pkg::F_GP};
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1;
    chk({16'h0, tr}, 32'h0);
    chk({31'h0, busy}, 32'h0);
    reg_wr(tss_pkg::REG_TR_SEL, 32'h0008);
    reg_wr(tss_pkg::REG_TR_BASE, 32'h0800);
    reg_wr(tss_pkg::REG_TR_DESC, 32'h0100);
    // Early faults: abandoned, reported one edge after the trigger is taken
    for (int i = 0; i < 9; i++) begin
      run_sw(rows[i].r);
      chk({29'h0, got.kind}, {29'h0, rows[i].f});
      chk({30'h0, got.valid, got.post}, 32'h2);
      chk(lat, 32'h1);
      chk({16'h0, got.sel}, {16'h0, rows[i].r.sel});
      chk({15'h0, ts, tr}, 32'h0008);
    end
    // Plain jump into a prepared context, limit exactly at the minimum
    for (int i = 0; i < 18; i++) begin
      i_tss_mem_model.mem[32'h1004 + 4 * i] = 32'h5A000000 + i;
    end
    i_tss_mem_model.mem[32'h1034] = 32'h5A000013;
    // Stack selector privilege 3, matching the loaded code privilege
    i_tss_mem_model.mem[32'h1038] = 32'h5A00000F;
    chk_in <= {1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1, 1'b1, 2'h3, 4'hF, 4'hF, 4'h0, 8'hFF};
    run_sw(mk(tss_pkg::K_JUMP, 1'h0, 2'h0, 2'h0, 16'h0010, 1'h1, 4'h9, 2'h0, 32'h67, 1'h1,
      32'h1000, 32'h200));
    chk({30'h0, got_done, got.valid}, 32'h2);
    chk({15'h0, ts, tr}, 32'h1_0010);
    chk({30'h0, current_privilege}, 32'h3);
    chk({31'h0, nt}, 32'h0);
    chk(nload, 32'd18);
    chk(lw[3], 32'h5A000003);
    chk(i_tss_mem_model.mem[32'h0810], 32'hC0034000);
    chk(i_tss_mem_model.mem[32'h0848], 32'hC0114000);
    chk({28'h0, i_tss_mem_model.mem[32'h0105][3:0]}, 32'h9);
    chk({28'h0, i_tss_mem_model.mem[32'h0205][3:0]}, 32'hB);
    // Slow memory, nested invoke ending in a stack fault after commit
    slow <= 1'b1;
    chk_in <= {1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1, 1'b0, 2'h3, 4'hF, 4'hF, 4'h0, 8'hFF};
    run_sw(mk(tss_pkg::K_INVOKE, 1'h0, 2'h0, 2'h3, 16'h0018, 1'h1, 4'h9, 2'h3, 32'h68, 1'h1,
      32'h2000, 32'h300));
    chk({29'h0, got_done, got.valid, got.post}, 32'h7);
    chk({29'h0, got.kind}, {29'h0, tss_pkg::F_SF});
    chk({16'h0, got.sel}, 32'h0000DFC7);
    chk({15'h0, nt, tr}, 32'h1_0018);
    chk({16'h0, i_tss_mem_model.mem[32'h2000][15:0]}, 32'h0010);
    chk({28'h0, i_tss_mem_model.mem[32'h0205][3:0]}, 32'hB);
    // Nested return to the linked task
    slow <= 1'b0;
    chk_in <= {1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 1'b1, 1'b1, 2'h0, 4'hF, 4'hF, 4'h0, 8'h00};
    run_sw(mk(tss_pkg::K_INTERRUPT_RETURN, 1'h0, 2'h0, 2'h0, 16'h0000, 1'h1, 4'hB, 2'h0, 32'h67, 1'h1,
      32'h1000, 32'h200));
    chk({30'h0, got_done, got.valid}, 32'h2);
    chk({16'h0, tr}, 32'h0010);
    chk({29'h0, nt, current_privilege}, 32'h4);
    chk(lw[3], 32'hC0034000);
    chk(i_tss_mem_model.mem[32'h200C], 32'hC0020000);
    chk({28'h0, i_tss_mem_model.mem[32'h0305][3:0]}, 32'h9);
    // Return with the nested flag clear is no switch
    reg_wr(tss_pkg::REG_CTRL, 32'h0);
    @(posedge i_clk);
    trig <= 1'b1;
    @(posedge i_clk);
    trig <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 chk({31'h0, busy}, 32'h0);
    // Register port: status, flag clear, unmapped place
    reg_rd(tss_pkg::REG_STAT);
    chk(v & 32'h0000_FE07, 32'h0000_0201);
    reg_wr(tss_pkg::REG_CTRL, 32'h2);
    reg_rd(tss_pkg::REG_CTRL);
    chk(v, 32'h0);
    reg_rd(3'h7);
    chk(v, 32'h0);
    close_out();
  end
endmodule
